// ===== rtl/assc_pkg.sv
package assc_pkg;
   // register indices (word address = index, byte address = 4*index)
   localparam logic [7:0] REG_CTRL = 8'h00;      // [3:0] enable, [6:4] average_factor
   localparam logic [7:0] REG_TRIG = 8'h01;      // 4 x (src[1:0], prio[1:0]) at 4*n
   localparam logic [7:0] REG_SWTRIG = 8'h02;    // write 1 per sequencer
   localparam logic [7:0] REG_IRQ_MASK = 8'h03;
   localparam logic [7:0] REG_IRQ_STAT = 8'h04;  // [3:0] raw, [7:4] masked, write 1 clears
   localparam logic [7:0] REG_OVF = 8'h05;       // [3:0] overflow, write 1 clears
   localparam logic [7:0] REG_STEP_BASE = 8'h10; // 8 slots per sequencer, 0x10..0x2f
   localparam logic [7:0] REG_FIFO_BASE = 8'h30; // 0x30..0x33 pop, [11:0] data
   localparam logic [7:0] REG_FIFO_CNT = 8'h34;  // 4 x 4-bit counts
   // step word layout
   localparam int STEP_CH_LSB = 0;   // [3:0]: 0..7 channel, 8 temperature sensor
   localparam int STEP_LAST_BIT = 4;
   localparam int STEP_IRQ_BIT = 5;
   localparam logic [3:0] CH_TEMP = 4'h8;
   localparam logic [2:0] AVG_OFF = 3'h0;
   localparam logic [2:0] AVG_MAX = 3'h6;
   localparam logic [3:0] FIFO_DEPTH = 4'h8;
   typedef enum logic [1:0] {
      ASSC_TRIG_SW = 2'b00,
      ASSC_TRIG_PIN = 2'b01,
      ASSC_TRIG_TIMER = 2'b10,
      ASSC_TRIG_ALWAYS = 2'b11
   } assc_trig_e;
   typedef enum logic [1:0] {
      ASSC_IDLE = 2'b00,
      ASSC_CONV = 2'b01,
      ASSC_WAIT = 2'b10
   } assc_state_e;
endpackage : assc_pkg

// ===== rtl/assc_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - eight channels plus temperature sensor per step
// - four sequencers, each own trigger source
// - depths eight, four, four, one steps
// - each step picks its own input
// - strict priority arbitration, starvation possible
// - average 2 to 64 conversions
// - factor zero passes raw conversions
// - one averaging factor for all sequencers
// - fifo gets only fully averaged results
// - 1 << factor conversions per delivered result
// - clear drops pending sequencer interrupt
// - separate mask bit per sequencer
// - raw and masked status both readable
// - software trigger only if source is software
// - two-bit priority, zero highest, ties go to lowest sequencer
// - software, pin, timer, always sources
// - step last flag and interrupt flag
// - sticky overflow on non-always trigger with unread results
module assc_top (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic ext_trig,
   input wire logic timer_trig,
   output logic conv_start,
   output logic [3:0] conv_channel,
   input wire logic conv_done,
   input wire logic [11:0] conv_data,
   output logic irq
);
   localparam logic [3:0] DEPTH [4] = '{4'h8, 4'h4, 4'h4, 4'h1};
   logic [3:0] seq_en;
   logic [2:0] average_factor;
   logic [1:0] trig_src [4];
   logic [1:0] sequencer_priority [4];
   logic [5:0] step_cfg [32];
   logic [3:0] irq_raw;
   logic [3:0] irq_mask;
   logic [3:0] ovf;
   logic [3:0] pend;
   logic [11:0] fifo [4][8];
   logic [2:0] wptr [4];
   logic [2:0] rptr [4];
   logic [3:0] cnt [4];
   assc_pkg::assc_state_e state;
   logic [1:0] sequencer_index;
   logic [2:0] step;
   logic [6:0] avg_cnt;
   logic [17:0] acc;
   logic [3:0] trig_now;
   logic [3:0] sw_trig;
   logic [3:0] push;
   logic [3:0] pop;
   logic found;
   logic [1:0] win;
   logic [6:0] avg_n;
   logic [5:0] cur;
   logic [17:0] sum;
   logic [11:0] result;
   logic last_step_flag;
   logic step_irq_flag;

   assign avg_n = (average_factor == assc_pkg::AVG_OFF) ? 7'h01
      : 7'(1 << average_factor);
   assign cur = step_cfg[{sequencer_index, step}];
   assign last_step_flag = cur[assc_pkg::STEP_LAST_BIT] ||
      ({1'b0, step} == DEPTH[sequencer_index] - 4'h1);
   assign step_irq_flag = cur[assc_pkg::STEP_IRQ_BIT];
   assign sum = acc + {6'h00, conv_data};
   assign result = 12'(sum >> average_factor);
   assign sw_trig = (wr && addr == assc_pkg::REG_SWTRIG) ? wdata[3:0] : 4'h0;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_seq
         always_comb begin
            case (assc_pkg::assc_trig_e'(trig_src[g]))
               assc_pkg::ASSC_TRIG_SW: trig_now[g] = sw_trig[g];
               assc_pkg::ASSC_TRIG_PIN: trig_now[g] = ext_trig;
               assc_pkg::ASSC_TRIG_TIMER: trig_now[g] = timer_trig;
               default: trig_now[g] = 1'b1;
            endcase
         end
         assign push[g] = state == assc_pkg::ASSC_CONV && conv_done && sequencer_index == g &&
            avg_cnt == avg_n - 7'h01 && cnt[g] != assc_pkg::FIFO_DEPTH;
         assign pop[g] = rd && addr == assc_pkg::REG_FIFO_BASE + 8'(g) && cnt[g] != 4'h0;
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               pend[g] <= 1'b0;
               ovf[g] <= 1'b0;
               irq_raw[g] <= 1'b0;
               wptr[g] <= 3'h0;
               rptr[g] <= 3'h0;
               cnt[g] <= 4'h0;
            end else begin
               if (trig_now[g] && seq_en[g]) begin
                  pend[g] <= 1'b1;
               end else if (state == assc_pkg::ASSC_IDLE && found && win == g) begin
                  pend[g] <= 1'b0;
               end
               if (wr && addr == assc_pkg::REG_OVF && wdata[g]) begin
                  ovf[g] <= 1'b0;
               end
               if (trig_now[g] && seq_en[g] && cnt[g] != 4'h0 &&
                   trig_src[g] != assc_pkg::ASSC_TRIG_ALWAYS) begin
                  ovf[g] <= 1'b1;
               end
               if (wr && addr == assc_pkg::REG_IRQ_STAT && wdata[g]) begin
                  irq_raw[g] <= 1'b0;
               end
               if (push[g] && step_irq_flag) begin
                  irq_raw[g] <= 1'b1;
               end
               if (push[g]) begin
                  fifo[g][wptr[g]] <= result;
                  wptr[g] <= wptr[g] + 3'h1;
               end
               if (pop[g]) begin
                  rptr[g] <= rptr[g] + 3'h1;
               end
               cnt[g] <= cnt[g] + {3'h0, push[g]} - {3'h0, pop[g]};
            end
         end
      end
   endgenerate

   // strict priority pick among pending sequencers
   always_comb begin
      found = 1'b0;
      win = 2'h0;
      for (int p = 0; p < 4; p++) begin
         for (int s = 0; s < 4; s++) begin
            if (!found && pend[s] && seq_en[s] && sequencer_priority[s] == 2'(p)) begin
               found = 1'b1;
               win = 2'(s);
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         seq_en <= 4'h0;
         average_factor <= assc_pkg::AVG_OFF;
         irq_mask <= 4'h0;
         for (int s = 0; s < 4; s++) begin
            trig_src[s] <= 2'h0;
            sequencer_priority[s] <= 2'(s);
         end
      end else if (wr) begin
         if (addr == assc_pkg::REG_CTRL) begin
            seq_en <= wdata[3:0];
            if (wdata[6:4] <= assc_pkg::AVG_MAX) begin
               average_factor <= wdata[6:4];
            end
         end
         if (addr == assc_pkg::REG_TRIG) begin
            for (int s = 0; s < 4; s++) begin
               trig_src[s] <= wdata[4*s+2 +: 2];
               sequencer_priority[s] <= wdata[4*s +: 2];
            end
         end
         if (addr == assc_pkg::REG_IRQ_MASK) begin
            irq_mask <= wdata[3:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (wr && addr >= assc_pkg::REG_STEP_BASE && addr < assc_pkg::REG_FIFO_BASE) begin
         step_cfg[5'(addr - assc_pkg::REG_STEP_BASE)] <= wdata[5:0];
      end
   end

   // conversion sequencing
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= assc_pkg::ASSC_IDLE;
         sequencer_index <= 2'h0;
         step <= 3'h0;
         avg_cnt <= 7'h00;
         acc <= 18'h0_0000;
         conv_start <= 1'b0;
         conv_channel <= 4'h0;
      end else begin
         conv_start <= 1'b0;
         case (state)
            assc_pkg::ASSC_IDLE: begin
               if (found) begin
                  sequencer_index <= win;
                  step <= 3'h0;
                  avg_cnt <= 7'h00;
                  acc <= 18'h0_0000;
                  conv_channel <= step_cfg[{win, 3'h0}][3:0];
                  conv_start <= 1'b1;
                  state <= assc_pkg::ASSC_CONV;
               end
            end
            assc_pkg::ASSC_CONV: begin
               if (conv_done) begin
                  if (avg_cnt != avg_n - 7'h01) begin
                     avg_cnt <= avg_cnt + 7'h01;
                     acc <= sum;
                     state <= assc_pkg::ASSC_WAIT;
                  end else if (last_step_flag) begin
                     state <= assc_pkg::ASSC_IDLE;
                  end else begin
                     step <= step + 3'h1;
                     avg_cnt <= 7'h00;
                     acc <= 18'h0_0000;
                     state <= assc_pkg::ASSC_WAIT;
                  end
               end
            end
            assc_pkg::ASSC_WAIT: begin
               conv_channel <= cur[3:0];
               conv_start <= 1'b1;
               state <= assc_pkg::ASSC_CONV;
            end
            default: state <= assc_pkg::ASSC_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_raw & irq_mask);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata <= 32'h0000_0000;
      end else if (rd) begin
         rdata <= 32'h0000_0000;
         case (addr)
            assc_pkg::REG_CTRL: rdata <= {25'h0, average_factor, seq_en};
            assc_pkg::REG_TRIG: begin
               for (int s = 0; s < 4; s++) begin
                  rdata[4*s +: 4] <= {trig_src[s], sequencer_priority[s]};
               end
            end
            assc_pkg::REG_IRQ_MASK: rdata <= {28'h0, irq_mask};
            assc_pkg::REG_IRQ_STAT: rdata <= {24'h0, irq_raw & irq_mask, irq_raw};
            assc_pkg::REG_OVF: rdata <= {28'h0, ovf};
            assc_pkg::REG_FIFO_CNT: rdata <= {16'h0, cnt[3], cnt[2], cnt[1], cnt[0]};
            default: begin
               if (addr >= assc_pkg::REG_FIFO_BASE && addr < assc_pkg::REG_FIFO_CNT) begin
                  rdata <= {20'h0, fifo[addr[1:0]][rptr[addr[1:0]]]};
               end else if (addr >= assc_pkg::REG_STEP_BASE && addr < assc_pkg::REG_FIFO_BASE) begin
                  rdata <= {26'h0, step_cfg[5'(addr - assc_pkg::REG_STEP_BASE)]};
               end
            end
         endcase
      end else begin
         rdata <= 32'h0000_0000;
      end
   end

   chk_irq_masked_out: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 irq == |($past(irq_raw) & $past(irq_mask))) else $error("irq not raw and mask");
   chk_clear_drops_raw: assert property (@(posedge clk) disable iff (!rst_n)
      (wr && addr == assc_pkg::REG_IRQ_STAT && wdata[3] && !push[3]) |=> !irq_raw[3])
      else $error("irq clear ignored");
   chk_disabled_no_pend: assert property (@(posedge clk) disable iff (!rst_n)
      (!seq_en[0] && !pend[0]) |=> !pend[0]) else $error("disabled sequencer triggered");
   chk_start_after_grant: assert property (@(posedge clk) disable iff (!rst_n)
      (state == assc_pkg::ASSC_IDLE && found) |=> conv_start && sequencer_index == $past(win))
      else $error("grant did not start");
   chk_sw_only_sw: assert property (@(posedge clk) disable iff (!rst_n)
      (trig_src[1] == assc_pkg::ASSC_TRIG_PIN && !ext_trig && !pend[1]) |=> !pend[1])
      else $error("sw trigger leaked");
   chk_status_read: assert property (@(posedge clk) disable iff (!rst_n)
      (rd && addr == assc_pkg::REG_IRQ_STAT) |=> rdata[3:0] == $past(irq_raw))
      else $error("raw status read wrong");
   chk_fifo_bound: assert property (@(posedge clk) disable iff (!rst_n)
      cnt[0] <= assc_pkg::FIFO_DEPTH && cnt[3] <= assc_pkg::FIFO_DEPTH)
      else $error("fifo count beyond depth");
   chk_avg_off_push: assert property (@(posedge clk) disable iff (!rst_n)
      (state == assc_pkg::ASSC_CONV && conv_done && average_factor == assc_pkg::AVG_OFF &&
       cnt[sequencer_index] != assc_pkg::FIFO_DEPTH) |-> push[sequencer_index])
      else $error("raw conversion not passed");
   chk_depth_three: assert property (@(posedge clk) disable iff (!rst_n)
      (sequencer_index == 2'h3) |-> step == 3'h0) else $error("sequencer three beyond one step");
endmodule : assc_top

// ===== tb/assc_conv_model.sv
`timescale 1ns/1ps
module assc_conv_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic conv_start,
   input wire logic [3:0] conv_channel,
   output logic conv_done,
   output logic [11:0] conv_data
);
   logic [3:0] ch;
   logic [1:0] left;
   logic tog;
   // answers in one or three cycles by turns; data lsb alternates
   always_ff @(posedge clk) begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (!rst_n) begin
         left <= 2'h0;
         tog <= 1'b0;
         conv_data <= 12'h000;
      end else if (conv_start) begin
         ch <= conv_channel;
         left <= {tog, 1'b1};
      end else if (left == 2'h1) begin
         conv_done <= 1'b1;
         conv_data <= {ch, 7'h00, tog};
         tog <= ~tog;
         left <= 2'h0;
      end else if (left != 2'h0) begin
         left <= left - 2'h1;
      end
   end
endmodule : assc_conv_model

// ===== tb/test_adc_sample_sequencer_control.sv
`timescale 1ns/1ps
module test_adc_sample_sequencer_control;
   logic clk, rst_n, wr, rd, ext_trig, timer_trig, conv_start, conv_done, irq;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, v;
   logic [3:0] conv_channel;
   logic [11:0] conv_data;
   logic [3:0] chq[$];
   int dones, failures, compares;
   assc_top i_assc_top (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .ext_trig(ext_trig), .timer_trig(timer_trig),
      .conv_start(conv_start), .conv_channel(conv_channel), .conv_done(conv_done),
      .conv_data(conv_data), .irq(irq));
   assc_conv_model i_assc_conv_model (.clk(clk), .rst_n(rst_n), .conv_start(conv_start),
      .conv_channel(conv_channel), .conv_done(conv_done), .conv_data(conv_data));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      if (conv_start === 1'b1) chq.push_back(conv_channel);
      if (conv_done === 1'b1) dones++;
   end
   task automatic tally_and_finish();
      if (failures == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : rd_reg
   task automatic run(input logic [3:0] sw, input int n);
      chq.delete();
      dones = 0;
      wr_reg(assc_pkg::REG_SWTRIG, {28'h0, sw});
      for (int i = 0; dones < n; i++) begin
         if (i == 3000) begin
            failures++;
            tally_and_finish();
         end
         @(posedge clk);
      end
      repeat (2) @(posedge clk);
      #1;
   endtask : run
   task automatic t_reset();
      logic [7:0] a[5] = '{assc_pkg::REG_CTRL, assc_pkg::REG_IRQ_MASK,
         assc_pkg::REG_IRQ_STAT, assc_pkg::REG_OVF, 8'h0f};
      wr_reg(8'h0f, 32'hffff_ffff);
      foreach (a[i]) begin
         rd_reg(a[i]);
         check(v, 32'h0);
      end
      check(irq, 1'b0);
   endtask : t_reset
   task automatic t_seq0();
      logic [3:0] e;
      wr_reg(assc_pkg::REG_TRIG, 32'h0000_3210);
      for (int i = 0; i < 8; i++) begin
         wr_reg(assc_pkg::REG_STEP_BASE + 8'(i), (i < 7) ? 32'(7 - i) : 32'h0000_0018);
      end
      run(4'h1, 0);
      repeat (8) @(posedge clk);
      check(chq.size(), 0);
      wr_reg(assc_pkg::REG_CTRL, 32'h0000_0001);
      run(4'h1, 8);
      check(chq.size(), 8);
      rd_reg(assc_pkg::REG_FIFO_CNT);
      check(v[3:0], 4'h8);
      for (int i = 0; i < 8; i++) begin
         e = (i < 7) ? 4'(7 - i) : assc_pkg::CH_TEMP;
         check(chq[i], e);
         rd_reg(assc_pkg::REG_FIFO_BASE);
         check(v[11:0] & 12'hffe, {e, 8'h00});
      end
   endtask : t_seq0
   task automatic t_avg();
      int s;
      wr_reg(assc_pkg::REG_STEP_BASE + 8'h10, 32'h0000_0016);
      wr_reg(assc_pkg::REG_STEP_BASE + 8'h18, 32'h0000_0000);
      for (int k = 1; k < 7; k++) begin
         s = 2 + (k % 2);
         wr_reg(assc_pkg::REG_CTRL, 32'((k << 4) | 12));
         run(4'(1 << s), 1 << k);
         check(chq.size(), 1 << k);
         rd_reg(assc_pkg::REG_FIFO_BASE + 8'(s));
         check(v[11:0], (s == 2) ? 12'h600 : 12'h000);
      end
      wr_reg(assc_pkg::REG_CTRL, 32'h0000_007c);
      rd_reg(assc_pkg::REG_CTRL);
      check(v[6:4], 3'h6);
   endtask : t_avg
   task automatic t_irq();
      wr_reg(assc_pkg::REG_CTRL, 32'h0000_0008);
      wr_reg(assc_pkg::REG_STEP_BASE + 8'h18, 32'h0000_0020);
      run(4'h8, 1);
      rd_reg(assc_pkg::REG_IRQ_STAT);
      check(v[7:0], 8'h08);
      check(irq, 1'b0);
      run(4'h8, 1);
      rd_reg(assc_pkg::REG_OVF);
      check(v[3:0], 4'h8);
      wr_reg(assc_pkg::REG_OVF, 32'h0000_0008);
      rd_reg(assc_pkg::REG_OVF);
      check(v[3:0], 4'h0);
      wr_reg(assc_pkg::REG_IRQ_STAT, 32'h0000_0008);
      wr_reg(assc_pkg::REG_IRQ_MASK, 32'h0000_0008);
      rd_reg(assc_pkg::REG_IRQ_MASK);
      check(irq, 1'b0);
      run(4'h8, 1);
      rd_reg(assc_pkg::REG_IRQ_STAT);
      check(v[7:0], 8'h88);
      check(irq, 1'b1);
      wr_reg(assc_pkg::REG_IRQ_STAT, 32'h0000_0008);
      rd_reg(assc_pkg::REG_IRQ_STAT);
      check(v[7:0], 8'h00);
      check(irq, 1'b0);
   endtask : t_irq
   task automatic t_trig();
      wr_reg(assc_pkg::REG_STEP_BASE + 8'h08, 32'h0000_0015);
      wr_reg(assc_pkg::REG_CTRL, 32'h0000_0006);
      wr_reg(assc_pkg::REG_TRIG, 32'h0000_3102);
      run(4'h6, 2);
      check(chq[0], 4'h5);
      wr_reg(assc_pkg::REG_TRIG, 32'h0000_3012);
      run(4'h6, 2);
      check(chq[0], 4'h6);
      wr_reg(assc_pkg::REG_TRIG, 32'h0000_3942);
      run(4'h6, 0);
      repeat (8) @(posedge clk);
      check(chq.size(), 0);
      ext_trig <= 1'b1;
      @(posedge clk);
      ext_trig <= 1'b0;
      run(4'h0, 1);
      check(chq[0], 4'h5);
      @(posedge clk);
      timer_trig <= 1'b1;
      @(posedge clk);
      timer_trig <= 1'b0;
      run(4'h0, 1);
      check(chq[0], 4'h6);
      wr_reg(assc_pkg::REG_TRIG, 32'h0000_3d42);
      run(4'h0, 3);
      check(chq[2], 4'h6);
   endtask : t_trig
   initial begin
      rst_n = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      ext_trig = 1'b0;
      timer_trig = 1'b0;
      failures = 0;
      compares = 0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_seq0();
      t_avg();
      t_irq();
      t_trig();
      tally_and_finish();
   end
endmodule : test_adc_sample_sequencer_control
